/* File: core/rrsx_pkg.sv */
package rrsx_pkg;

	localparam int RRSX_PC_WIDTH = 15;
	localparam int RRSX_STACK_DEPTH = 16;
	localparam int RRSX_FILE_DEPTH = 128;
	localparam int RRSX_PRESCALE_WIDTH = 8;

	// register port offsets
	localparam logic [3:0] RRSX_REG_WORK = 4'h0;
	localparam logic [3:0] RRSX_REG_STATUS = 4'h1;
	localparam logic [3:0] RRSX_REG_PC_LO = 4'h2;
	localparam logic [3:0] RRSX_REG_PC_HI = 4'h3;
	localparam logic [3:0] RRSX_REG_WATCHDOG = 4'h4;
	localparam logic [3:0] RRSX_REG_CTRL = 4'h5;
	localparam logic [3:0] RRSX_REG_STACK = 4'h6;

	// status and control field positions
	localparam int RRSX_ST_CARRY = 0;
	localparam int RRSX_ST_POWER_DOWN = 1;
	localparam int RRSX_ST_TIMEOUT = 2;
	localparam int RRSX_ST_INT_EN = 3;
	localparam int RRSX_CTRL_SLEEP = 0;

	// values after reset
	localparam logic [7:0] RRSX_RST_WORK = 8'h00;
	localparam logic RRSX_RST_CARRY = 1'b0;
	localparam logic RRSX_RST_FLAG = 1'b1;
	localparam logic RRSX_RST_INT_EN = 1'b0;
	localparam logic [7:0] RRSX_WATCHDOG_CLEAR = 8'h00;

	// opcode field instr[13:8]
	localparam logic [5:0] RRSX_OPC_RET_LIT = 6'h01;
	localparam logic [5:0] RRSX_OPC_RET = 6'h02;
	localparam logic [5:0] RRSX_OPC_IRET = 6'h03;
	localparam logic [5:0] RRSX_OPC_ROT_L = 6'h04;
	localparam logic [5:0] RRSX_OPC_ROT_R = 6'h05;
	localparam logic [5:0] RRSX_OPC_SLEEP = 6'h06;

	typedef enum logic [2:0] {
		OP_NONE, OP_RET_LIT, OP_RET, OP_IRET, OP_ROT_L, OP_ROT_R, OP_SLEEP
	} rrsx_op_e;

	typedef struct packed {
		rrsx_op_e op;
		logic dest;
		logic [6:0] faddr;
		logic [7:0] lit;
	} rrsx_instr_s;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [3:0] addr;
		logic [7:0] wdata;
	} rrsx_bus_s;

	function automatic rrsx_instr_s rrsx_decode(input logic [13:0] word);
		rrsx_instr_s d;
		d.dest = word[7];
		d.faddr = word[6:0];
		d.lit = word[7:0];
		case (word[13:8])
			RRSX_OPC_RET_LIT: d.op = OP_RET_LIT;
			RRSX_OPC_RET: d.op = OP_RET;
			RRSX_OPC_IRET: d.op = OP_IRET;
			RRSX_OPC_ROT_L: d.op = OP_ROT_L;
			RRSX_OPC_ROT_R: d.op = OP_ROT_R;
			RRSX_OPC_SLEEP: d.op = OP_SLEEP;
			default: d.op = OP_NONE;
		endcase
		return d;
	endfunction : rrsx_decode

	function automatic logic rrsx_is_return(input rrsx_op_e op);
		return (op == OP_RET_LIT) || (op == OP_RET) || (op == OP_IRET);
	endfunction : rrsx_is_return

endpackage : rrsx_pkg

/* File: core/rrsx_mem.sv */
`timescale 1ns/10ps
module rrsx_mem #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 128
) (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic wr_en,
	input wire logic [$clog2(DEPTH)-1:0] wr_addr,
	input wire logic [WIDTH-1:0] wr_data,
	input wire logic [$clog2(DEPTH)-1:0] rd_addr,
	output logic [WIDTH-1:0] rd_data
);

	logic [WIDTH-1:0] mem [DEPTH];

	// array has no reset so it maps onto plain ram
	always_ff @(posedge core_clk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			rd_data <= '0;
		end else begin
			rd_data <= mem[rd_addr];
		end
	end

endmodule : rrsx_mem

/* File: core/rrsx_exec.sv */
`timescale 1ns/10ps
module rrsx_exec
	import rrsx_pkg::*;
#(
	parameter int PC_WIDTH = RRSX_PC_WIDTH,
	parameter int STACK_DEPTH = RRSX_STACK_DEPTH,
	parameter int PRESCALE_WIDTH = RRSX_PRESCALE_WIDTH
) (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic instr_valid,
	input wire logic [13:0] instr,
	input wire logic push_valid,
	input wire logic [PC_WIDTH-1:0] push_addr,
	input wire rrsx_bus_s bus_req,
	output logic [7:0] bus_rdata,
	output logic busy,
	output logic done,
	output logic [PC_WIDTH-1:0] pc,
	output logic [7:0] w_reg,
	output logic carry,
	output logic timeout_flag,
	output logic power_down_flag,
	output logic global_interrupt_enable,
	output logic [7:0] watchdog_counter,
	output logic sleeping
);

	localparam int SPW = $clog2(STACK_DEPTH);
	localparam int FAW = $clog2(RRSX_FILE_DEPTH);

	typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_FLUSH} rrsx_state_e;

	rrsx_state_e state;
	rrsx_instr_s dec, cur;
	logic take, push_ok, finishing, ret_start;
	logic [SPW-1:0] sp, top_addr;
	logic [PC_WIDTH-1:0] top_of_stack_entry;
	logic [7:0] file_rdata, rot_res;
	logic rot_carry, file_wr, exec_sleep, exec_rot;
	logic [PRESCALE_WIDTH-1:0] watchdog_prescale;

	assign dec = rrsx_decode(instr);
	assign take = instr_valid && (state == ST_IDLE) && !sleeping && (dec.op != OP_NONE);
	// a push in the issue cycle would move the top that the pop reads
	assign push_ok = push_valid && (state == ST_IDLE) && !take;
	assign top_addr = sp - 1'b1;
	assign finishing = ((state == ST_EXEC) && !rrsx_is_return(cur.op)) || (state == ST_FLUSH);
	assign exec_sleep = (state == ST_EXEC) && (cur.op == OP_SLEEP);
	assign exec_rot = (state == ST_EXEC) && ((cur.op == OP_ROT_L) || (cur.op == OP_ROT_R));

	always_comb begin
		if (cur.op == OP_ROT_L) begin
			rot_res = {file_rdata[6:0], carry};
			rot_carry = file_rdata[7];
		end else begin
			rot_res = {carry, file_rdata[7:1]};
			rot_carry = file_rdata[0];
		end
	end

	assign file_wr = exec_rot && cur.dest;

	rrsx_mem #(
		.WIDTH(8),
		.DEPTH(RRSX_FILE_DEPTH)
	) u_file (
		.core_clk(core_clk),
		.reset_n(reset_n),
		.wr_en(file_wr),
		.wr_addr(cur.faddr[FAW-1:0]),
		.wr_data(rot_res),
		.rd_addr(dec.faddr[FAW-1:0]),
		.rd_data(file_rdata)
	);

	rrsx_mem #(
		.WIDTH(PC_WIDTH),
		.DEPTH(STACK_DEPTH)
	) u_stack (
		.core_clk(core_clk),
		.reset_n(reset_n),
		.wr_en(push_ok),
		.wr_addr(sp),
		.wr_data(push_addr),
		.rd_addr(top_addr),
		.rd_data(top_of_stack_entry)
	);

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			state <= ST_IDLE;
			cur <= '0;
		end else begin
			case (state)
				ST_IDLE: begin
					if (take) begin
						state <= ST_EXEC;
						cur <= dec;
					end
				end
				ST_EXEC: begin
					// returns spend a second cycle refetching at the new pc
					state <= rrsx_is_return(cur.op) ? ST_FLUSH : ST_IDLE;
				end
				ST_FLUSH: state <= ST_IDLE;
				default: state <= ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			busy <= 1'b0;
			done <= 1'b0;
		end else begin
			busy <= take || (busy && !finishing);
			done <= finishing;
		end
	end

	// stack pointer wraps; depth checking is left to the rest of the core
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			sp <= '0;
		end else if ((state == ST_EXEC) && rrsx_is_return(cur.op)) begin
			sp <= sp - 1'b1;
		end else if (push_ok) begin
			sp <= sp + 1'b1;
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			pc <= '0;
		end else if ((state == ST_EXEC) && rrsx_is_return(cur.op)) begin
			pc <= top_of_stack_entry;
		end
	end

	// hardware result wins over a software write in the same cycle
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			w_reg <= RRSX_RST_WORK;
		end else if ((state == ST_EXEC) && (cur.op == OP_RET_LIT)) begin
			w_reg <= cur.lit;
		end else if (exec_rot && !cur.dest) begin
			w_reg <= rot_res;
		end else if (bus_req.wr && (bus_req.addr == RRSX_REG_WORK)) begin
			w_reg <= bus_req.wdata;
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			carry <= RRSX_RST_CARRY;
		end else if (exec_rot) begin
			carry <= rot_carry;
		end else if (bus_req.wr && (bus_req.addr == RRSX_REG_STATUS)) begin
			carry <= bus_req.wdata[RRSX_ST_CARRY];
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			global_interrupt_enable <= RRSX_RST_INT_EN;
		end else if ((state == ST_EXEC) && (cur.op == OP_IRET)) begin
			global_interrupt_enable <= 1'b1;
		end else if (bus_req.wr && (bus_req.addr == RRSX_REG_STATUS)) begin
			global_interrupt_enable <= bus_req.wdata[RRSX_ST_INT_EN];
		end
	end

	// flags are read-only to software, only sleep moves them here
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			timeout_flag <= RRSX_RST_FLAG;
			power_down_flag <= RRSX_RST_FLAG;
		end else if (exec_sleep) begin
			timeout_flag <= 1'b1;
			power_down_flag <= 1'b0;
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			sleeping <= 1'b0;
		end else if (exec_sleep) begin
			sleeping <= 1'b1;
		end else if (bus_req.wr && (bus_req.addr == RRSX_REG_CTRL) &&
				bus_req.wdata[RRSX_CTRL_SLEEP]) begin
			sleeping <= 1'b0;
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			watchdog_prescale <= '0;
			watchdog_counter <= RRSX_WATCHDOG_CLEAR;
		end else if (exec_sleep) begin
			watchdog_prescale <= '0;
			watchdog_counter <= RRSX_WATCHDOG_CLEAR;
		end else begin
			watchdog_prescale <= watchdog_prescale + 1'b1;
			if (&watchdog_prescale) begin
				watchdog_counter <= watchdog_counter + 8'h01;
			end
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			bus_rdata <= 8'h00;
		end else if (bus_req.rd) begin
			case (bus_req.addr)
				RRSX_REG_WORK: bus_rdata <= w_reg;
				RRSX_REG_STATUS: begin
					bus_rdata <= 8'h00;
					bus_rdata[RRSX_ST_CARRY] <= carry;
					bus_rdata[RRSX_ST_POWER_DOWN] <= power_down_flag;
					bus_rdata[RRSX_ST_TIMEOUT] <= timeout_flag;
					bus_rdata[RRSX_ST_INT_EN] <= global_interrupt_enable;
				end
				RRSX_REG_PC_LO: bus_rdata <= pc[7:0];
				RRSX_REG_PC_HI: bus_rdata <= 8'(pc >> 8);
				RRSX_REG_WATCHDOG: bus_rdata <= watchdog_counter;
				RRSX_REG_CTRL: bus_rdata <= {7'h00, sleeping};
				RRSX_REG_STACK: bus_rdata <= 8'(sp);
				default: bus_rdata <= 8'h00;
			endcase
		end else begin
			bus_rdata <= 8'h00;
		end
	end

	assign ret_start = take && rrsx_is_return(dec.op);
	AST_RETLIT_W: assert property (@(posedge core_clk) disable iff (!reset_n)
		(state == ST_EXEC) && (cur.op == OP_RET_LIT) |=> w_reg == $past(cur.lit))
		else $error("literal return did not load W");
	AST_RET_FLAGS: assert property (@(posedge core_clk) disable iff (!reset_n)
		(state == ST_EXEC) && (cur.op == OP_RET_LIT) && !bus_req.wr
		|=> $stable(carry) && $stable(timeout_flag) && $stable(power_down_flag))
		else $error("literal return changed a status flag");
	AST_RET_TIMING: assert property (@(posedge core_clk) disable iff (!reset_n)
		ret_start |=> busy && !done ##1 busy && !done ##1 done && !busy)
		else $error("return did not take two execute cycles");
	AST_RET_PC: assert property (@(posedge core_clk) disable iff (!reset_n)
		(state == ST_EXEC) && rrsx_is_return(cur.op)
		|=> (pc == $past(top_of_stack_entry)) && (sp == $past(top_addr)))
		else $error("return did not pop the stack into pc");
	AST_ROT_L: assert property (@(posedge core_clk) disable iff (!reset_n)
		exec_rot && (cur.op == OP_ROT_L) |=> carry == $past(file_rdata[7]))
		else $error("left rotate carry wrong");
	AST_ROT_W: assert property (@(posedge core_clk) disable iff (!reset_n)
		exec_rot && !cur.dest |=> w_reg == (($past(cur.op) == OP_ROT_L) ?
		{$past(file_rdata[6:0]), $past(carry)} : {$past(carry), $past(file_rdata[7:1])}))
		else $error("rotate result missing from W");
	AST_ROT_R: assert property (@(posedge core_clk) disable iff (!reset_n)
		exec_rot && (cur.op == OP_ROT_R)
		|=> (carry == $past(file_rdata[0])) && (w_reg[7] == $past(carry) || $past(cur.dest)))
		else $error("right rotate wrong");
	AST_SLEEP_FLAGS: assert property (@(posedge core_clk) disable iff (!reset_n)
		exec_sleep && !bus_req.wr |=> timeout_flag && !power_down_flag && $stable(carry)
		&& $stable(global_interrupt_enable))
		else $error("sleep status flags wrong");
	AST_SLEEP_WATCHDOG: assert property (@(posedge core_clk) disable iff (!reset_n)
		exec_sleep |=> (watchdog_counter == 8'h00) && (watchdog_prescale == '0) && sleeping)
		else $error("sleep did not clear the watchdog");
	AST_IRET_INT_EN: assert property (@(posedge core_clk) disable iff (!reset_n)
		(state == ST_EXEC) && (cur.op == OP_IRET) |=> global_interrupt_enable ##1 done)
		else $error("interrupt return did not enable interrupts");
	COV_RETLIT: cover property (@(posedge core_clk) disable iff (!reset_n)
		take && (dec.op == OP_RET_LIT) ##3 done);
	COV_ROT_FILE: cover property (@(posedge core_clk) disable iff (!reset_n)
		file_wr);
	COV_SLEEP: cover property (@(posedge core_clk) disable iff (!reset_n)
		exec_sleep ##1 sleeping);
	COV_IRET: cover property (@(posedge core_clk) disable iff (!reset_n)
		(state == ST_EXEC) && (cur.op == OP_IRET));

endmodule : rrsx_exec

/* File: testbench/tb_rrsx_exec.sv */
`timescale 1ns/10ps
module tb_rrsx_exec;
	import rrsx_pkg::*;
	typedef struct packed {
		logic [5:0] opc;
		logic d;
		logic [6:0] f;
		logic [7:0] v;
		logic cin;
		logic [7:0] res;
		logic cout;
	} rrsx_row_s;
	logic core_clk, reset_n, instr_valid, push_valid;
	logic [13:0] instr;
	logic [RRSX_PC_WIDTH-1:0] push_addr;
	rrsx_bus_s bus_req;
	logic [7:0] bus_rdata, w_reg, watchdog_counter, rd, exp_f;
	logic [RRSX_PC_WIDTH-1:0] pc;
	logic busy, done, carry, timeout_flag, power_down_flag, global_interrupt_enable, sleeping;
	int fail_count = 0;
	int comparisons = 0;
	rrsx_row_s rows [4] = '{
		'{RRSX_OPC_ROT_L, 1'b0, 7'h05, 8'hE6, 1'b0, 8'hCC, 1'b1},
		'{RRSX_OPC_ROT_R, 1'b0, 7'h05, 8'hE6, 1'b1, 8'hF3, 1'b0},
		'{RRSX_OPC_ROT_L, 1'b1, 7'h7F, 8'h81, 1'b1, 8'h03, 1'b1},
		'{RRSX_OPC_ROT_R, 1'b1, 7'h00, 8'h01, 1'b0, 8'h00, 1'b1}};
	rrsx_exec #(.PRESCALE_WIDTH(2)) dut_u (.core_clk(core_clk), .reset_n(reset_n),
		.instr_valid(instr_valid), .instr(instr), .push_valid(push_valid),
		.push_addr(push_addr), .bus_req(bus_req), .bus_rdata(bus_rdata), .busy(busy),
		.done(done), .pc(pc), .w_reg(w_reg), .carry(carry), .timeout_flag(timeout_flag),
		.power_down_flag(power_down_flag),
		.global_interrupt_enable(global_interrupt_enable),
		.watchdog_counter(watchdog_counter), .sleeping(sleeping));
	initial begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end
	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : give_verdict
	task automatic bus_write(input logic [3:0] a, input logic [7:0] d);
		@(posedge core_clk);
		bus_req <= {1'b1, 1'b0, a, d};
		@(posedge core_clk);
		bus_req <= '0;
	endtask : bus_write
	task automatic bus_read(input logic [3:0] a, output logic [7:0] d);
		@(posedge core_clk);
		bus_req <= {1'b0, 1'b1, a, 8'h00};
		@(posedge core_clk);
		bus_req <= '0;
		#1 d = bus_rdata;
	endtask : bus_read
	task automatic push(input logic [RRSX_PC_WIDTH-1:0] a);
		@(posedge core_clk);
		push_valid <= 1'b1;
		push_addr <= a;
		@(posedge core_clk);
		push_valid <= 1'b0;
	endtask : push
	// issue one instruction and count edges from the take edge to done
	task automatic run(input logic [13:0] word, input int lat);
		int n;
		@(posedge core_clk);
		instr <= word;
		instr_valid <= 1'b1;
		@(posedge core_clk);
		instr_valid <= 1'b0;
		n = 1;
		#1 check("busy", busy, 1'b1);
		while (done !== 1'b1 && n < 20) begin
			@(posedge core_clk);
			n++;
			#1;
		end
		if (n >= 20) begin
			fail_count++;
			give_verdict();
		end
		check("latency", n[15:0], lat[15:0]);
	endtask : run
	// a file register is only reachable through rotates, so fill it via the carry
	task automatic load_file(input logic [6:0] f, input logic [7:0] v);
		for (int i = 7; i >= 0; i--) begin
			bus_write(RRSX_REG_STATUS, {7'h00, v[i]});
			run({RRSX_OPC_ROT_L, 1'b1, f}, 2);
		end
	endtask : load_file
	initial begin
		reset_n = 1'b0;
		instr_valid = 1'b0;
		instr = 14'h0000;
		push_valid = 1'b0;
		push_addr = '0;
		bus_req = '0;
		repeat (6) @(posedge core_clk);
		check("reset pc", {1'b0, pc}, 16'h0000);
		check("reset w", w_reg, 8'h00);
		check("reset flags", {global_interrupt_enable, timeout_flag, power_down_flag}, 3'h3);
		reset_n <= 1'b1;
		bus_read(4'hF, rd);
		check("unmapped", rd, 8'h00);
		$display("test reset done");
		foreach (rows[i]) begin
			load_file(rows[i].f, rows[i].v);
			bus_write(RRSX_REG_WORK, 8'h5A);
			bus_write(RRSX_REG_STATUS, {7'h00, rows[i].cin});
			run({rows[i].opc, rows[i].d, rows[i].f}, 2);
			check("rot w", w_reg, rows[i].d ? 8'h5A : rows[i].res);
			check("rot carry", carry, rows[i].cout);
			exp_f = rows[i].d ? rows[i].res : rows[i].v;
			bus_write(RRSX_REG_STATUS, 8'h00);
			run({RRSX_OPC_ROT_L, 1'b0, rows[i].f}, 2);
			check("rot file", {w_reg, 7'h00, carry}, {exp_f[6:0], 1'b0, 7'h00, exp_f[7]});
		end
		$display("test rotate rows done");
		bus_write(RRSX_REG_STATUS, 8'h01);
		for (int i = 0; i < 2; i++) begin
			push(15'h2A55 + i[14:0]);
			run({RRSX_OPC_RET_LIT, i ? 8'hFF : 8'h00}, 3);
			check("ret lit w", w_reg, i ? 8'hFF : 8'h00);
			check("ret lit pc", pc, 15'h2A55 + i[14:0]);
		end
		push(15'h1234);
		push(15'h7FFF);
		push(15'h0001);
		bus_read(RRSX_REG_STACK, rd);
		check("stack ptr", rd, 8'h03);
		run({RRSX_OPC_RET_LIT, 8'hA5}, 3);
		check("ret lit", {pc, 1'b0}, {15'h0001, 1'b0});
		check("ret lit w", w_reg, 8'hA5);
		run({RRSX_OPC_RET, 8'h00}, 3);
		check("ret pc", pc, 15'h7FFF);
		check("ret w", w_reg, 8'hA5);
		check("ret gie", global_interrupt_enable, 1'b0);
		run({RRSX_OPC_IRET, 8'h00}, 3);
		check("iret pc", pc, 15'h1234);
		check("iret gie", global_interrupt_enable, 1'b1);
		bus_read(RRSX_REG_STATUS, rd);
		check("flags kept", rd, 8'h0F);
		$display("test returns done");
		for (int n = 0; watchdog_counter === 8'h00; n++) begin
			if (n > 40) begin
				fail_count++;
				give_verdict();
			end
			@(posedge core_clk);
		end
		// carry and interrupt enable set so that sleep leaving them alone is visible
		bus_write(RRSX_REG_STATUS, 8'h09);
		run({RRSX_OPC_SLEEP, 8'h00}, 2);
		check("sleep watchdog", watchdog_counter, RRSX_WATCHDOG_CLEAR);
		check("sleep flags", {timeout_flag, power_down_flag}, 2'h2);
		check("sleep others", {carry, global_interrupt_enable, sleeping}, 3'h7);
		// prescaler of 2 bits: a cleared prescaler needs exactly 4 edges for one count
		repeat (3) @(posedge core_clk);
		#1 check("prescaler held", watchdog_counter, 8'h00);
		@(posedge core_clk);
		#1 check("prescaler cleared", watchdog_counter, 8'h01);
		bus_write(RRSX_REG_CTRL, 8'h01);
		#1 check("wake", sleeping, 1'b0);
		$display("test sleep done");
		give_verdict();
	end
endmodule : tb_rrsx_exec
